/* File: hdl/supervisor_reset_watchdog.sv */
// supply supervisor: reset pulse, watchdog, power-fail flag, backup switch
//
// What this block does
// RULE1: reset is asserted while the supply is below threshold and when the watchdog expires.
// RULE2: after supply recovery or a watchdog expiry reset stays asserted for one 200 ms pulse.
// RULE3: a service input held at one valid level for the 1.6 s timeout triggers a reset.
// RULE4: a floating service input disables the watchdog and never causes a reset.
// RULE5: the watchdog counter is held clear whenever reset is asserted.
// RULE6: the host holds each service level for at least 50 ns, and any such change services.
// RULE7: the service input decodes as low, high or floating, floating being neither logic value.
// RULE8: the active-high reset output is always the exact inverse of the active-low one.
// RULE9: on main supply the power-fail flag is low while the sense input is below reference, else high.
// RULE10: main feeds the switched supply while above threshold, backup once main is below both.
// RULE11: below threshold backup takes over at +20 mV and main returns at +20 mV, 40 mV apart.
// RULE12: a supply dip during a reset pulse restarts the full pulse interval.
// RULE13: the watchdog counts only with reset released and a valid level on the service input.
// RULE14: a static service input yields one reset every timeout plus pulse width.
// RULE15: while backup feeds the switched supply the power-fail flag is forced low.
// RULE16: timers run on the internal clock and comparator outputs are synchronised first.
`timescale 1ns/1ns
`default_nettype none
`include "supervisor_map.svh"

module supervisor_reset_watchdog #(
	parameter int unsigned RESET_PULSE_CYCLES = `SUP_RESET_PULSE_MS * `SUP_CLK_KHZ,
	parameter int unsigned WD_TIMEOUT_CYCLES  = `SUP_WD_TIMEOUT_MS * `SUP_CLK_KHZ
) (
	// clock and reset
	input  wire logic                    ref_clk,
	input  wire logic                    srst,
	// comparator outputs from the analog front end
	input  wire supervisor_pkg::sense_s  sense,
	// reset to the host, both polarities
	output logic                         reset_n,
	output logic                         reset,
	// power-fail flag to the host, active low
	output logic                         power_fail_flag_output_n,
	// supply switch control, high selects the backup battery
	output logic                         switched_supply_from_backup
);
	import supervisor_pkg::*;

	// ==========================================================
	// derived counts
	localparam logic [31:0] PULSE_LAST = 32'(RESET_PULSE_CYCLES - 1);
	localparam logic [31:0] WD_LAST    = 32'(WD_TIMEOUT_CYCLES - 1);
	// least service pulse in clock cycles, rounded up
	localparam int unsigned WDI_PULSE_CYCLES =
		(`SUP_WDI_PULSE_NS + `SUP_CLK_PERIOD_NS - 1) / `SUP_CLK_PERIOD_NS;

	// ==========================================================
	// synchronised comparator outputs
	sense_s     sync_sense;
	sup_regs_s  q;
	sup_regs_s  next_q;
	wdi_level_e wdi_level;
	logic       wdi_toggle;
	logic       wd_expire;

	// RULE16 sync comparator outputs
	sense_sync #(
		.WIDTH     (`SUP_SENSE_W),
		.RESET_VAL (`SUP_SENSE_RST)
	) u_sense_sync (
		.ref_clk  (ref_clk),
		.srst     (srst),
		.async_in (sense),
		.sync_out (sync_sense)
	);

	// ==========================================================
	// three-level decode of the service input
	function automatic wdi_level_e decode_wdi(input logic above_high, input logic below_low);
		wdi_level_e lvl;
		// RULE7 three state decode
		if (above_high && !below_low) begin
			lvl = WDI_HIGH;
		end else if (below_low && !above_high) begin
			lvl = WDI_LOW;
		end else begin
			lvl = WDI_FLOAT;  // mid level or contradictory comparators
		end
		return lvl;
	endfunction

	assign wdi_level = decode_wdi(sync_sense.wdi_above_high, sync_sense.wdi_below_low);

	// a change between the two valid levels services the watchdog;
	// drifting through the floating band does not, it disables instead
	// RULE6 any valid transition services
	assign wdi_toggle = (wdi_level != q.wdi_prev) && (wdi_level != WDI_FLOAT)
		&& (q.wdi_prev != WDI_FLOAT);

	// RULE3 expiry at the timeout count
	assign wd_expire = (q.state == ST_RUN) && (wdi_level != WDI_FLOAT) && !wdi_toggle
		&& (q.wd_cnt == WD_LAST);

	// ==========================================================
	// next state
	always_comb begin
		next_q          = q;
		next_q.wdi_prev = wdi_level;

		// reset sequencer
		unique case (q.state)
			ST_POWER_LOW: begin
				next_q.pulse_cnt = `SUP_CNT_ZERO;
				// RULE2 pulse starts on recovery
				if (!sync_sense.supply_low) begin
					next_q.state = ST_RESET_PULSE;
				end
			end
			ST_RESET_PULSE: begin
				// RULE12 dip restarts pulse
				if (sync_sense.supply_low) begin
					next_q.state     = ST_POWER_LOW;
					next_q.pulse_cnt = `SUP_CNT_ZERO;
				end else if (q.pulse_cnt == PULSE_LAST) begin
					next_q.state     = ST_RUN;
					next_q.pulse_cnt = `SUP_CNT_ZERO;
				end else begin
					next_q.pulse_cnt = q.pulse_cnt + `SUP_CNT_ONE;
				end
			end
			ST_RUN: begin
				// RULE1 low supply or expiry
				if (sync_sense.supply_low) begin
					next_q.state = ST_POWER_LOW;
				end else if (wd_expire) begin
					// RULE14 static input repeats
					next_q.state = ST_RESET_PULSE;
				end
			end
			default: begin
				next_q.state = ST_POWER_LOW;
			end
		endcase

		// watchdog counter
		// RULE5 cleared under reset
		// RULE4 floating input disables
		// RULE13 counts only when released
		if (next_q.state != ST_RUN || q.state != ST_RUN || wdi_level == WDI_FLOAT
				|| wdi_toggle) begin
			next_q.wd_cnt = `SUP_CNT_ZERO;
		end else begin
			next_q.wd_cnt = q.wd_cnt + `SUP_CNT_ONE;
		end

		// supply switch, held in the dead band between the two 20 mV points
		// RULE10 main above threshold
		if (!sync_sense.supply_low) begin
			next_q.backup_sel = 1'b0;
		// RULE11 switchover hysteresis
		end else if (sync_sense.batt_above_main_20mv) begin
			next_q.backup_sel = 1'b1;
		end else if (sync_sense.main_above_batt_20mv) begin
			next_q.backup_sel = 1'b0;
		end

		// power-fail flag; comparator is off on battery to save charge
		// RULE15 forced low on backup
		// RULE9 follows the comparator
		next_q.power_fail_n = !next_q.backup_sel && !sync_sense.pfi_below_ref;

		next_q.reset_n = (next_q.state == ST_RUN);
	end

	// ==========================================================
	// state register
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			q <= '{state: ST_POWER_LOW, pulse_cnt: `SUP_CNT_ZERO, wd_cnt: `SUP_CNT_ZERO,
				wdi_prev: WDI_FLOAT, backup_sel: 1'b0, power_fail_n: 1'b0, reset_n: 1'b0};
		end else begin
			q <= next_q;
		end
	end

	// ==========================================================
	// outputs
	assign reset_n                     = q.reset_n;
	// RULE8 exact inverse
	assign reset                       = ~q.reset_n;
	assign power_fail_flag_output_n    = q.power_fail_n;
	assign switched_supply_from_backup = q.backup_sel;

	// ==========================================================
	// checks
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (srst);

	// low supply asserts reset on the next cycle
	property p_supply_low_resets;
		sync_sense.supply_low |=> !reset_n;
	endproperty
	a_supply_low_resets: assert property (p_supply_low_resets) // RULE1
		else $error("reset not asserted under low supply");

	// reset releases only at the end of a full pulse
	property p_pulse_width;
		$rose(reset_n) |-> $past(q.state) == ST_RESET_PULSE && $past(q.pulse_cnt) == PULSE_LAST;
	endproperty
	a_pulse_width: assert property (p_pulse_width) // RULE2
		else $error("reset released before the full pulse");

	// expiry starts a new reset pulse
	property p_wd_expiry;
		(q.state == ST_RUN && !sync_sense.supply_low && wdi_level != WDI_FLOAT && !wdi_toggle
			&& q.wd_cnt == WD_LAST) |=> (q.state == ST_RESET_PULSE && !reset_n
			&& q.pulse_cnt == `SUP_CNT_ZERO);
	endproperty
	a_wd_expiry: assert property (p_wd_expiry) // RULE3
		else $error("watchdog expiry did not start a reset pulse");

	// floating input keeps the counter clear and reset released
	property p_float_disables;
		(q.state == ST_RUN && wdi_level == WDI_FLOAT && !sync_sense.supply_low)
			|=> (q.wd_cnt == `SUP_CNT_ZERO && reset_n);
	endproperty
	a_float_disables: assert property (p_float_disables) // RULE4
		else $error("floating service input did not hold the watchdog off");

	// counter clear under reset
	property p_clear_in_reset;
		!reset_n |-> q.wd_cnt == `SUP_CNT_ZERO;
	endproperty
	a_clear_in_reset: assert property (p_clear_in_reset) // RULE5
		else $error("watchdog counter runs during reset");

	// a valid toggle restarts the count
	property p_toggle_services;
		wdi_toggle |=> q.wd_cnt == `SUP_CNT_ZERO;
	endproperty
	a_toggle_services: assert property (p_toggle_services) // RULE6
		else $error("service toggle did not clear the watchdog");

	// both reset outputs move together
	property p_inverse;
		$changed(reset_n) |-> $changed(reset) && (reset != reset_n);
	endproperty
	a_inverse: assert property (p_inverse) // RULE8
		else $error("reset outputs not complementary");

	// power-fail flag follows comparator on main
	property p_power_fail;
		(!sync_sense.supply_low && sync_sense.pfi_below_ref)
			|=> !power_fail_flag_output_n && !switched_supply_from_backup;
	endproperty
	a_power_fail: assert property (p_power_fail) // RULE9
		else $error("power-fail flag missed a low sense input");

	// above threshold always on main
	property p_main_above;
		!sync_sense.supply_low |=> !switched_supply_from_backup;
	endproperty
	a_main_above: assert property (p_main_above) // RULE10
		else $error("backup selected while main above threshold");

	// switchover at +20 mV, hold in the band
	property p_hysteresis;
		(sync_sense.supply_low && !sync_sense.batt_above_main_20mv
			&& !sync_sense.main_above_batt_20mv) |=> $stable(switched_supply_from_backup);
	endproperty
	a_hysteresis: assert property (p_hysteresis) // RULE11
		else $error("supply switch moved inside the hysteresis band");

	// dip in a pulse restarts it
	property p_restart;
		(q.state == ST_RESET_PULSE && sync_sense.supply_low)
			|=> q.state == ST_POWER_LOW ##1 q.pulse_cnt == `SUP_CNT_ZERO;
	endproperty
	a_restart: assert property (p_restart) // RULE12
		else $error("supply dip did not restart the reset pulse");

	// flag low on backup
	property p_backup_flag;
		switched_supply_from_backup |-> !power_fail_flag_output_n;
	endproperty
	a_backup_flag: assert property (p_backup_flag) // RULE15
		else $error("power-fail flag high on backup supply");

	// counter held clear outside run or with a floating input
	property p_count_gate;
		(q.state != ST_RUN || wdi_level == WDI_FLOAT) |=> q.wd_cnt == `SUP_CNT_ZERO;
	endproperty
	a_count_gate: assert property (p_count_gate) // RULE13
		else $error("watchdog counted outside run or while floating");

	// both service comparators high is floating, never a valid level
	property p_both_float;
		(q.state == ST_RUN && sync_sense.wdi_above_high && sync_sense.wdi_below_low)
			|=> q.wd_cnt == `SUP_CNT_ZERO;
	endproperty
	a_both_float: assert property (p_both_float) // RULE7
		else $error("contradictory service comparators taken as a level");

	// a finished pulse releases reset with a fresh count, so a static
	// input expires again one full timeout later
	property p_periodic_restart;
		(q.state == ST_RESET_PULSE && q.pulse_cnt == PULSE_LAST && !sync_sense.supply_low)
			|=> (reset_n && q.wd_cnt == `SUP_CNT_ZERO);
	endproperty
	a_periodic_restart: assert property (p_periodic_restart) // RULE14
		else $error("pulse end did not restart the watchdog from zero");

	cover property (q.state == ST_RUN ##1 q.state == ST_RESET_PULSE);
	cover property (q.state == ST_RESET_PULSE ##1 q.state == ST_POWER_LOW);
	cover property ($rose(switched_supply_from_backup));
	cover property (wdi_toggle && q.wd_cnt > `SUP_CNT_ONE && WDI_PULSE_CYCLES > 0);
	cover property (q.state == ST_RUN && wdi_level == WDI_FLOAT ##1 reset_n);

endmodule // supervisor_reset_watchdog

`default_nettype wire

/* File: hdl/supervisor_map.svh */
// timing constants and reset values of the supply supervisor
`ifndef SUPERVISOR_MAP_SVH
`define SUPERVISOR_MAP_SVH

// ==========================================================
// clock
`define SUP_CLK_KHZ          100000
`define SUP_CLK_PERIOD_NS    10

// ==========================================================
// reset pulse width, milliseconds (nominal, least, longest)
`define SUP_RESET_PULSE_MS   200
`define SUP_RESET_PULSE_MIN  140
`define SUP_RESET_PULSE_MAX  280

// ==========================================================
// watchdog timeout period, milliseconds (nominal, least, longest)
`define SUP_WD_TIMEOUT_MS    1600
`define SUP_WD_TIMEOUT_MIN   1000
`define SUP_WD_TIMEOUT_MAX   2250

// ==========================================================
// least service pulse on the watchdog input, nanoseconds
`define SUP_WDI_PULSE_NS     50

// ==========================================================
// widths and reset values
`define SUP_CNT_W            32
`define SUP_CNT_ZERO         32'h0000_0000
`define SUP_CNT_ONE          32'h0000_0001
`define SUP_SENSE_W          6
// supply-low sync stage resets high so reset holds through the flush
`define SUP_SENSE_RST        6'h01

`endif

/* File: hdl/supervisor_pkg.sv */
// types shared by the supply supervisor
package supervisor_pkg;

	// ==========================================================
	// comparator outputs, one bit each, from the analog front end
	typedef struct packed {
		logic main_above_batt_20mv;  // main exceeds backup by 20 mV
		logic batt_above_main_20mv;  // backup exceeds main by 20 mV
		logic pfi_below_ref;         // sense input below 1.25 V ref
		logic wdi_below_low;         // service input at logic low
		logic wdi_above_high;        // service input at logic high
		logic supply_low;            // main below reset threshold
	} sense_s;

	// ==========================================================
	// decoded watchdog service level
	typedef enum logic [1:0] {
		WDI_FLOAT = 2'b00,
		WDI_LOW   = 2'b01,
		WDI_HIGH  = 2'b11
	} wdi_level_e;

	// ==========================================================
	// reset sequencer, gray along power-low, pulse, run
	typedef enum logic [1:0] {
		ST_POWER_LOW   = 2'b00,
		ST_RESET_PULSE = 2'b01,
		ST_RUN         = 2'b11
	} sup_state_e;

	// ==========================================================
	// whole state of the supervisor
	typedef struct packed {
		sup_state_e  state;
		logic [31:0] pulse_cnt;
		logic [31:0] wd_cnt;
		wdi_level_e  wdi_prev;
		logic        backup_sel;
		logic        power_fail_n;
		logic        reset_n;
	} sup_regs_s;

endpackage : supervisor_pkg

/* File: hdl/sense_sync.sv */
// two-flop synchroniser for the comparator outputs
`timescale 1ns/1ns
`default_nettype none

module sense_sync #(
	parameter int unsigned                  WIDTH     = 6,
	parameter logic        [WIDTH-1:0]      RESET_VAL = '0
) (
	// clock and reset
	input  wire logic               ref_clk,
	input  wire logic               srst,
	// asynchronous levels in, synchronous levels out
	input  wire logic [WIDTH-1:0]   async_in,
	output logic      [WIDTH-1:0]   sync_out
);

	logic [WIDTH-1:0] stage1;

	// first stage feeds only the second stage
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			stage1   <= RESET_VAL;
			sync_out <= RESET_VAL;
		end else begin
			stage1   <= async_in;
			sync_out <= stage1;
		end
	end

endmodule // sense_sync

`default_nettype wire

/* File: tb/host_service_model.sv */
// host model that services or holds the watchdog service input
`timescale 1ns/1ns
`default_nettype none

module host_service_model (
	// clock and reset seen by the host
	input  wire logic       ref_clk,
	input  wire logic       reset_n,
	// 0 floating, 1 held high, 2 held low, 3 toggling service
	input  wire logic [1:0] mode,
	// service level as the front end decodes it
	output logic            wdi_high,
	output logic            wdi_low
);
	logic [4:0] tick;
	logic       lvl;

	// ==========================================================
	// drive on the falling edge; a host held in reset stops servicing
	initial begin
		tick = 5'h00;
		lvl = 1'b0;
		wdi_high = 1'b0;
		wdi_low = 1'b0;
	end
	always @(negedge ref_clk) begin
		tick <= tick + 5'h01;
		if (mode == 2'h3 && reset_n && tick >= 5'h13) begin
			lvl <= ~lvl;
			tick <= 5'h00;
		end
		case (mode)
			2'h0: {wdi_high, wdi_low} <= {2{tick[0]}};
			2'h1: {wdi_high, wdi_low} <= 2'b10;
			2'h2: {wdi_high, wdi_low} <= 2'b01;
			default: {wdi_high, wdi_low} <= {lvl, ~lvl};
		endcase
	end
endmodule // host_service_model
`default_nettype wire

/* File: tb/test_supervisor_reset_watchdog.sv */
// self-checking bench for the supply supervisor
`timescale 1ns/1ns
`default_nettype none

module test_supervisor_reset_watchdog;
	import supervisor_pkg::*;
	localparam int unsigned PW  = 20;
	localparam int unsigned WD  = 50;
	localparam int unsigned ANY = 32'h7fff_ffff;

	// one expected change of the outputs and its allowed gap in cycles
	typedef struct packed {
		logic        rst_n;
		logic        flag_n;
		logic        bkp;
		logic [31:0] lo;
		logic [31:0] hi;
	} note_s;

	logic        ref_clk;
	logic        srst;
	sense_s      sense;
	sense_s      drv;
	logic        reset_n;
	logic        reset;
	logic        flag_n;
	logic        bkp;
	logic        wdi_high;
	logic        wdi_low;
	logic [1:0]  mode;
	logic [2:0]  prev;
	logic        v;
	note_s       n;
	note_s       notes[$];
	int          fails;
	int          checks_done;
	int          seed;
	int unsigned cyc;
	int unsigned gap;

	// ==========================================================
	// design and host
	supervisor_reset_watchdog #(
		.RESET_PULSE_CYCLES(PW),
		.WD_TIMEOUT_CYCLES (WD)
	) dut (
		.ref_clk                    (ref_clk),
		.srst                       (srst),
		.sense                      (sense),
		.reset_n                    (reset_n),
		.reset                      (reset),
		.power_fail_flag_output_n   (flag_n),
		.switched_supply_from_backup(bkp)
	);
	host_service_model host (
		.ref_clk (ref_clk),
		.reset_n (reset_n),
		.mode    (mode),
		.wdi_high(wdi_high),
		.wdi_low (wdi_low)
	);

	// service comparators come from the host, the rest from the bench
	always_comb begin
		sense = drv;
		sense.wdi_above_high = wdi_high;
		sense.wdi_below_low = wdi_low;
	end

	always #5 ref_clk = ~ref_clk;

	// ==========================================================
	// helpers
	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		checks_done++;
		if (seen !== exp) begin
			fails++;
			$display("[FAIL] %0t %s: seen %h expected %h", $time, what, seen, exp);
		end
	endtask

	task automatic expect_chg(input logic [2:0] lv, input int unsigned lo, input int unsigned hi);
		notes.push_back('{lv[2], lv[1], lv[0], lo, hi});
	endtask

	task automatic idle(input int unsigned k);
		repeat (k) @(negedge ref_clk);
	endtask

	// bounded wait until every noted result has shown up
	task automatic wait_empty(input string name);
		int unsigned k;
		k = 0;
		while (notes.size() != 0 && k < 600) begin
			@(negedge ref_clk);
			k++;
		end
		check(notes.size(), 0, "results missing"); // every note consumed
		$display("test %s done", name);
	endtask

	task automatic complete_run;
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// ==========================================================
	// watcher: every output change takes the oldest note; the gap
	// is judged from the last change, so scenarios keep changes apart
	always @(negedge ref_clk) begin
		cyc++;
		gap++;
		if (!srst && {reset_n, flag_n, bkp} !== prev) begin
			if (notes.size() == 0) begin
				check({29'h0, reset_n, flag_n, bkp}, {29'h0, prev}, "unexpected change"); // quiet
			end else begin
				n = notes.pop_front();
				check({29'h0, reset_n, flag_n, bkp}, {29'h0, n.rst_n, n.flag_n, n.bkp}, "outputs"); // levels
				check({31'h0, reset}, {31'h0, ~reset_n}, "polarity"); // inverse
				check({31'h0, gap >= n.lo && gap <= n.hi}, 32'h1, "gap"); // timing
			end
			gap = 0;
		end
		prev = {reset_n, flag_n, bkp};
		if (cyc == 5000) begin
			fails++;
			complete_run;
		end
	end

	// ==========================================================
	// driver
	initial begin
		ref_clk = 1'b0;
		srst = 1'b1;
		drv = '0;
		mode = 2'h3;
		prev = 3'h0;
		seed = 11;
		fails = 0;
		checks_done = 0;
		cyc = 0;
		gap = 0;
		idle(3);
		expect_chg(3'b010, 0, ANY);
		expect_chg(3'b110, PW - 2, PW + 6);
		srst = 1'b0;
		wait_empty("power_up");
		// flag follows the sense input while the host keeps servicing
		for (int i = 0; i < 16; i++) begin
			v = 1'($random(seed));
			if (v != drv.pfi_below_ref)
				expect_chg({1'b1, ~v, 1'b0}, 0, ANY);
			drv.pfi_below_ref = v;
			idle(5 + $unsigned($random(seed)) % 8);
		end
		if (drv.pfi_below_ref)
			expect_chg(3'b110, 0, ANY);
		drv.pfi_below_ref = 1'b0;
		idle(200);
		wait_empty("service");
		// static levels: expiry, pulse, then periodic expiries
		mode = 2'h1;
		expect_chg(3'b010, 0, ANY);
		expect_chg(3'b110, PW, PW + 3);
		expect_chg(3'b010, WD, WD + 3);
		wait_empty("static_high");
		mode = 2'h2;
		expect_chg(3'b110, PW, PW + 3);
		expect_chg(3'b010, WD, WD + 3);
		expect_chg(3'b110, PW, PW + 3);
		wait_empty("static_low");
		mode = 2'h0;
		idle(3 * WD);
		wait_empty("floating");
		// a second dip inside the pulse restarts it
		expect_chg(3'b010, 0, ANY);
		expect_chg(3'b110, PW + 17, PW + 23);
		drv.supply_low = 1'b1;
		idle(5);
		drv.supply_low = 1'b0;
		idle(10);
		drv.supply_low = 1'b1;
		idle(5);
		drv.supply_low = 1'b0;
		wait_empty("dip");
		// switch-over with hysteresis, flag forced low on backup
		expect_chg(3'b001, 0, ANY);
		drv.supply_low = 1'b1;
		drv.batt_above_main_20mv = 1'b1;
		idle(10);
		drv.batt_above_main_20mv = 1'b0;
		idle(10);
		expect_chg(3'b010, 0, ANY);
		drv.main_above_batt_20mv = 1'b1;
		idle(10);
		expect_chg(3'b001, 0, ANY);
		drv.main_above_batt_20mv = 1'b0;
		drv.batt_above_main_20mv = 1'b1;
		idle(10);
		expect_chg(3'b010, 0, ANY);
		expect_chg(3'b110, PW - 1, PW + 2);
		drv.supply_low = 1'b0;
		wait_empty("backup");
		complete_run;
	end
endmodule // test_supervisor_reset_watchdog
`default_nettype wire
